// ==== hw/stream_ctrl_pkg.sv ====
package stream_ctrl_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_ROUTING    = 8'h00;
  localparam logic [7:0] OFF_CLK_STREAM = 8'h04;
  localparam logic [7:0] OFF_SAMPLE0_I  = 8'h08;
  localparam logic [7:0] OFF_SAMPLE0_Q  = 8'h0C;
  localparam logic [7:0] OFF_SAMPLE1_I  = 8'h10;
  localparam logic [7:0] OFF_SAMPLE1_Q  = 8'h14;
  localparam logic [7:0] OFF_SAMPLE2_I  = 8'h18;
  localparam logic [7:0] OFF_SAMPLE2_Q  = 8'h1C;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int PORT_STRIDE  = 8;  // One byte of routing per port
  localparam int ENABLE_LSB   = 0;  // Six loop enables within the byte
  localparam int FORMAT_POS   = 6;
  localparam int APPEND_POS   = 7;
  localparam int DIV_LSB      = 8;
  localparam int MASTER_POS   = 7;
  localparam int CPLX_LSB     = 4;
  localparam int STREAM_LSB   = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] ROUTING_RST    = 32'h0000_0000;
  localparam logic [9:0]  CLK_STREAM_RST = 10'h000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic [15:0] strength;
    logic        valid;
    logic        strength_upd;
  } loop_sample_t;

  typedef enum logic [1:0] {WORD_I, WORD_Q, WORD_IQ8, WORD_GAIN} word_kind_t;

  typedef struct packed {
    logic        valid;
    word_kind_t  kind;
    logic [2:0]  loop;
    logic [15:0] data;
  } port_word_t;

  typedef enum {ST_IDLE, ST_I, ST_Q, ST_GAIN, ST_OVERHEAD} frame_state_t;

endpackage : stream_ctrl_pkg

// ==== hw/output_port_stream_control.sv ====
// Behaviour
// - Append bit set: strength word follows every I/Q sample on that port.
// - Append bit clear: strength word only after a strength update, once.
// - Format bit set gives 8-bit parallel I/Q, clear gives 16-bit interleave.
// - Six enable bits per port route gain loops onto that port.
// - A loop whose enable bit is clear when its first word is due is skipped on that port.
// - Master port clock is internal clock divided by 2, 4 or 8; divide by 1 holds the pin high.
// - Master bit set: drive port clock pin and launch data on it.
// - Master bit clear: port clock pin is input; data follows it.
// - Master bit is clear after reset, so the pin is not driven.
// - Complex codes 001/010/011 pair loops 0/1, then 2/3, then 4/5.
// - Codes 101/110/111 form the same pairs as biphase filters.
// - Code 000 applies no pairing; stream field alone groups loops.
// - Stream codes 0000 to 0100 merge the leading two to six loops.
// - Codes 0101 to 1001 form grouped streams; others stay independent.
// - Read-only registers hold latest in-phase sample of loops 0 to 2.
// - Read-only registers hold latest quadrature sample of loops 0 to 2.
// - Sample registers capture the loop output even when loop bypassed.
// - Each output frame ends with one extra overhead clock cycle.
// - All words of one channel leave on a single port.
// - Output words are two's complement.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module output_port_stream_control
#(
  parameter int NUM_LOOPS = 6,
  parameter int NUM_PORTS = 3,
  parameter int NUM_SREGS = 3
)
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output      logic [31:0]                  prdata,
  output      logic                         pready,
  output      logic                         pslverr,
  // Gain loop outputs
  input  wire stream_ctrl_pkg::loop_sample_t [5:0] loop_in,
  input  wire logic                         frame_strobe,
  // Port clock pin
  input  wire logic                         port_clk_in,
  output      logic                         port_clk_out,
  output      logic                         port_clk_oe,
  // Output ports A, B, C
  output      stream_ctrl_pkg::port_word_t [2:0] port_out,
  // Stream and complex grouping
  output      logic [5:0][2:0]              stream_group,
  output      logic [2:0]                   complex_pairs,
  output      logic [2:0]                   biphase_pairs
);
  import stream_ctrl_pkg::*;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Lowest enabled loop at or above from; bit 3 set when none
  function automatic logic [3:0] next_enabled(input logic [5:0] mask,
                                              input logic [2:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int k = NUM_LOOPS - 1; k >= 0; k--)
      if (mask[k] && (3'(k) >= from))
        r = {1'b0, 3'(k)};
    return r;
  endfunction : next_enabled

  function automatic logic [2:0] div_last(input logic [1:0] code);
    logic [2:0] r;
    case (code)
      2'h0:    r = 3'h0;
      2'h1:    r = 3'h1;
      2'h2:    r = 3'h3;
      default: r = 3'h7;
    endcase
    return r;
  endfunction : div_last

  // Group id of each loop is the lowest loop index of its stream
  function automatic logic [5:0][2:0] stream_map(input logic [3:0] code);
    logic [5:0][2:0] r;
    case (code)
      4'h0:    r = {3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h0};
      4'h1:    r = {3'h5, 3'h4, 3'h3, 3'h0, 3'h0, 3'h0};
      4'h2:    r = {3'h5, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
      4'h3:    r = {3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      4'h4:    r = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      4'h5:    r = {3'h3, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0};
      4'h6:    r = {3'h4, 3'h4, 3'h2, 3'h2, 3'h0, 3'h0};
      4'h7:    r = {3'h5, 3'h4, 3'h2, 3'h2, 3'h0, 3'h0};
      4'h8:    r = {3'h5, 3'h3, 3'h3, 3'h0, 3'h0, 3'h0};
      4'h9:    r = {3'h4, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
      default: r = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    endcase
    return r;
  endfunction : stream_map

  // Pair count 1..3 as a thermometer mask
  function automatic logic [2:0] pair_mask(input logic [1:0] n);
    logic [2:0] r;
    case (n)
      2'h1:    r = 3'h1;
      2'h2:    r = 3'h3;
      2'h3:    r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : pair_mask

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [31:0]                  routing_reg;
  logic [9:0]                   clk_stream_reg;
  logic [15:0]                  lat_i_reg [NUM_LOOPS];
  logic [15:0]                  lat_q_reg [NUM_LOOPS];
  logic [15:0]                  lat_s_reg [NUM_LOOPS];
  logic [NUM_PORTS-1:0][5:0]    gpend_reg;
  logic [NUM_PORTS-1:0]         start_reg;
  frame_state_t                 st_reg    [NUM_PORTS];
  frame_state_t                 st_next   [NUM_PORTS];
  logic [2:0]                   cur_reg   [NUM_PORTS];
  logic [2:0]                   cur_next  [NUM_PORTS];
  port_word_t                   word_next [NUM_PORTS];
  logic [2:0]                   div_cnt_reg;
  logic [2:0]                   div_cnt_next;
  logic                         pin_prev_reg;
  logic                         tick;
  logic                         master;
  logic [2:0]                   last;
  logic                         setup;
  logic                         wr_take;
  logic                         mapped;
  logic [31:0]                  rd_value;

  assign master = clk_stream_reg[MASTER_POS];
  assign last   = div_last(clk_stream_reg[DIV_LSB +: 2]);
  assign setup  = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One setup and one access cycle; pready is raised from the setup edge
  always_comb
  begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      OFF_ROUTING:    rd_value = routing_reg;
      OFF_CLK_STREAM: rd_value = {22'h0, clk_stream_reg};
      OFF_SAMPLE0_I:  rd_value = {16'h0000, lat_i_reg[0]};
      OFF_SAMPLE0_Q:  rd_value = {16'h0000, lat_q_reg[0]};
      OFF_SAMPLE1_I:  rd_value = {16'h0000, lat_i_reg[1]};
      OFF_SAMPLE1_Q:  rd_value = {16'h0000, lat_q_reg[1]};
      OFF_SAMPLE2_I:  rd_value = {16'h0000, lat_i_reg[2]};
      OFF_SAMPLE2_Q:  rd_value = {16'h0000, lat_q_reg[2]};
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= rd_value;
    end
  end

  // Writes to the sample registers are ignored without error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      routing_reg    <= ROUTING_RST;
      clk_stream_reg <= CLK_STREAM_RST;
    end
    else if (wr_take && !pslverr)
    begin
      if (paddr == OFF_ROUTING)
        routing_reg <= pwdata;
      if (paddr == OFF_CLK_STREAM)
        clk_stream_reg <= pwdata[9:0];
    end
  end

  // ------------------------------------------------------------------
  // Latest samples of every gain loop
  // ------------------------------------------------------------------
  // Taken at the loop output whether the loop runs or is bypassed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int k = 0; k < NUM_LOOPS; k++)
      begin
        lat_i_reg[k] <= 16'h0000;
        lat_q_reg[k] <= 16'h0000;
        lat_s_reg[k] <= 16'h0000;
      end
    else
      for (int k = 0; k < NUM_LOOPS; k++)
      begin
        if (loop_in[k].valid)
        begin
          lat_i_reg[k] <= loop_in[k].i;
          lat_q_reg[k] <= loop_in[k].q;
        end
        if (loop_in[k].strength_upd)
          lat_s_reg[k] <= loop_in[k].strength;
      end
  end

  // ------------------------------------------------------------------
  // Port clock
  // ------------------------------------------------------------------
  // Output clock rises with each new word; divide by 1 holds it high
  always_comb
  begin
    if (!master || div_cnt_reg == last)
      div_cnt_next = 3'h0;
    else
      div_cnt_next = div_cnt_reg + 3'h1;
    if (master)
      tick = (div_cnt_reg == last);
    else
      tick = port_clk_in && !pin_prev_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg  <= 3'h0;
      pin_prev_reg <= 1'b0;
      port_clk_out <= 1'b0;
      port_clk_oe  <= 1'b0;
    end
    else
    begin
      div_cnt_reg  <= div_cnt_next;
      pin_prev_reg <= port_clk_in;
      port_clk_out <= master && (div_cnt_next <= (last >> 1));
      port_clk_oe  <= master;
    end
  end

  // ------------------------------------------------------------------
  // Frame sequencers, one per port
  // ------------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      logic [5:0] en;
      logic       fmt;
      logic       due;
      logic [3:0] first;
      logic [3:0] nxt;
      frame_state_t adv;
      en    = routing_reg[p*PORT_STRIDE + ENABLE_LSB +: 6];
      fmt   = routing_reg[p*PORT_STRIDE + FORMAT_POS];
      due   = routing_reg[p*PORT_STRIDE + APPEND_POS]
              || gpend_reg[p][cur_reg[p]];
      first = next_enabled(en, 3'h0);
      nxt   = next_enabled(en, cur_reg[p] + 3'h1);
      adv   = nxt[3] ? ST_OVERHEAD : ST_I;
      st_next[p]   = st_reg[p];
      cur_next[p]  = cur_reg[p];
      word_next[p] = '0;
      word_next[p].loop = cur_reg[p];
      case (st_reg[p])
        ST_IDLE:
        begin
          if (start_reg[p] && !first[3])
          begin
            st_next[p]  = ST_I;
            cur_next[p] = first[2:0];
          end
        end
        ST_I:
        begin
          if (!en[cur_reg[p]])
          begin
            // Enable dropped mid-frame: skip the loop entirely
            st_next[p]  = adv;
            cur_next[p] = nxt[2:0];
          end
          else if (fmt)
          begin
            word_next[p].valid = 1'b1;
            word_next[p].kind  = WORD_IQ8;
            word_next[p].data  = {lat_i_reg[cur_reg[p]][15:8],
                                  lat_q_reg[cur_reg[p]][15:8]};
            st_next[p] = due ? ST_GAIN : adv;
            if (!due)
              cur_next[p] = nxt[2:0];
          end
          else
          begin
            word_next[p].valid = 1'b1;
            word_next[p].kind  = WORD_I;
            word_next[p].data  = lat_i_reg[cur_reg[p]];
            st_next[p] = ST_Q;
          end
        end
        ST_Q:
        begin
          // Same port as the I word, so a channel never splits
          word_next[p].valid = 1'b1;
          word_next[p].kind  = WORD_Q;
          word_next[p].data  = lat_q_reg[cur_reg[p]];
          st_next[p] = due ? ST_GAIN : adv;
          if (!due)
            cur_next[p] = nxt[2:0];
        end
        ST_GAIN:
        begin
          word_next[p].valid = 1'b1;
          word_next[p].kind  = WORD_GAIN;
          word_next[p].data  = lat_s_reg[cur_reg[p]];
          st_next[p]  = adv;
          cur_next[p] = nxt[2:0];
        end
        ST_OVERHEAD:
          st_next[p] = ST_IDLE;
        default:
          st_next[p] = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        st_reg[p]   <= ST_IDLE;
        cur_reg[p]  <= 3'h0;
        port_out[p] <= '0;
      end
    else if (tick)
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        st_reg[p]   <= st_next[p];
        cur_reg[p]  <= cur_next[p];
        port_out[p] <= word_next[p];
      end
  end

  // A strobe in the cycle that consumes the previous one is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_reg <= '0;
    else
      for (int p = 0; p < NUM_PORTS; p++)
        if (frame_strobe)
          start_reg[p] <= 1'b1;
        else if (tick && st_reg[p] == ST_IDLE)
          start_reg[p] <= 1'b0;
  end

  // Pending strength word per port and loop; a new update beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gpend_reg <= '0;
    else
      for (int p = 0; p < NUM_PORTS; p++)
        for (int k = 0; k < NUM_LOOPS; k++)
          if (loop_in[k].strength_upd)
            gpend_reg[p][k] <= 1'b1;
          else if (tick && st_reg[p] == ST_GAIN && cur_reg[p] == 3'(k))
            gpend_reg[p][k] <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Stream and complex grouping
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stream_group  <= stream_map(4'hF);
      complex_pairs <= 3'h0;
      biphase_pairs <= 3'h0;
    end
    else
    begin
      stream_group <=
        stream_map(clk_stream_reg[STREAM_LSB +: 4]);
      // Code 100 and 000 give no pairing
      complex_pairs <= clk_stream_reg[CPLX_LSB + 2] ? 3'h0
                       : pair_mask(clk_stream_reg[CPLX_LSB +: 2]);
      biphase_pairs <= clk_stream_reg[CPLX_LSB + 2]
                       ? pair_mask(clk_stream_reg[CPLX_LSB +: 2])
                       : 3'h0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  clk_pin_drive_a: assert property (
    wr_take && paddr == OFF_CLK_STREAM |-> ##2
      port_clk_oe == $past(pwdata[MASTER_POS], 2))
    else $error("port clock enable does not follow master bit");

  slave_no_drive_a: assert property (
    !master [*2] |-> !port_clk_oe && !port_clk_out)
    else $error("port clock driven in slave mode");

  sample_capture_a: assert property (
    loop_in[0].valid |=> lat_i_reg[0] == $past(loop_in[0].i)
                         && lat_q_reg[0] == $past(loop_in[0].q))
    else $error("loop 0 sample not captured");

  pair_decode_a: assert property (
    $stable(clk_stream_reg) [*2] |->
      ((clk_stream_reg[6:4] == 3'h3) == (complex_pairs == 3'h7))
      && ((clk_stream_reg[6:4] == 3'h4) == (biphase_pairs == 3'h0
          && complex_pairs == 3'h0 && clk_stream_reg[6:4] == 3'h4)))
    else $error("complex pairing decode wrong");

  stream_merge_a: assert property (
    clk_stream_reg[3:0] == 4'h4 ##1 clk_stream_reg[3:0] == 4'h4 |->
      stream_group == '0)
    else $error("all-merge stream code not applied");

  // Looks back, so a divisor write right after a tick cannot trip it
  div_period_a: assert property (
    $stable(clk_stream_reg) [*8] ##0
      (master && clk_stream_reg[9:8] == 2'h2 && tick) |->
      $past(tick, 4) && !$past(tick) && !$past(tick, 2)
      && !$past(tick, 3))
    else $error("divide by four period wrong");

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port_chk
    // Index taken from the new word, enable bit from the launching cycle
    routed_only_a: assert property (
      port_out[p].valid
        && ($rose(port_out[p].valid) || $changed(port_out[p].loop)) |->
        (($past(routing_reg) >> (p * PORT_STRIDE + ENABLE_LSB
          + int'(port_out[p].loop))) & 32'h0000_0001) != 32'h0000_0000)
      else $error("disabled loop placed on port");

    append_every_a: assert property (
      tick && st_reg[p] == ST_Q && routing_reg[p*PORT_STRIDE + APPEND_POS]
        |=> st_reg[p] == ST_GAIN)
      else $error("strength word not appended");

    no_stale_gain_a: assert property (
      tick && st_reg[p] == ST_Q && !routing_reg[p*PORT_STRIDE + APPEND_POS]
        && !gpend_reg[p][cur_reg[p]] |=> st_reg[p] != ST_GAIN)
      else $error("strength word sent without update");

    overhead_gap_a: assert property (
      tick && st_reg[p] == ST_OVERHEAD |=> !port_out[p].valid)
      else $error("frame overhead cycle missing");

    ascend_order_a: assert property (
      tick && st_reg[p] == ST_GAIN && st_next[p] == ST_I
        |=> cur_reg[p] > $past(cur_reg[p]))
      else $error("channels out of ascending order");
  end

endmodule : output_port_stream_control

// ==== testbench/stream_sink.sv ====
`timescale 1ns/100ps
module stream_sink
(
  // Clock and control
  input  wire logic                              pclk,
  input  wire logic                              clk_run,
  // Port bus from the device
  input  wire stream_ctrl_pkg::port_word_t [2:0] port_out,
  output      logic                              port_clk_in
);
  import stream_ctrl_pkg::*;

  port_word_t  got [3][$];
  port_word_t  last [3];
  int unsigned phase;

  function automatic void flush();
    for (int p = 0; p < 3; p++)
      got[p].delete();
  endfunction : flush

  // ----------------------------------------------------------------
  // Port clock: slow, and parked low while clk_run is clear
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (clk_run)
    begin
      phase <= (phase == 2) ? 0 : phase + 1;
      if (phase == 2)
        port_clk_in <= ~port_clk_in;
    end
    else
      port_clk_in <= 1'b0;
  end

  // Words hold between ticks, so a change marks a new word
  always @(posedge pclk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (port_out[p] !== last[p] && port_out[p].valid === 1'b1)
        got[p].push_back(port_out[p]);
      last[p] <= port_out[p];
    end
  end
endmodule : stream_sink

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import stream_ctrl_pkg::*;

  logic               pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic               pready, pslverr, frame_strobe, clk_run;
  logic               port_clk_in, port_clk_out, port_clk_oe;
  loop_sample_t [5:0] loop_in;
  port_word_t [2:0]   port_out;
  logic [5:0][2:0]    stream_group;
  logic [2:0]         complex_pairs, biphase_pairs;
  logic [17:0]        grp_tab [16];
  int                 bad_count, compares;

  output_port_stream_control uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_in(loop_in), .frame_strobe(frame_strobe),
    .port_clk_in(port_clk_in), .port_clk_out(port_clk_out),
    .port_clk_oe(port_clk_oe), .port_out(port_out),
    .stream_group(stream_group), .complex_pairs(complex_pairs),
    .biphase_pairs(biphase_pairs));

  stream_sink sink (.pclk(pclk), .clk_run(clk_run), .port_out(port_out),
    .port_clk_in(port_clk_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      $display("mismatch at %0t: %s", $time, msg);
      bad_count++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n == 1, "ready latency");
  endtask : apb

  task automatic load(int k, logic [15:0] i, logic [15:0] qv,
                      logic [15:0] s, logic upd);
    @(posedge pclk);
    loop_in[k].i <= i;
    loop_in[k].q <= qv;
    loop_in[k].strength <= s;
    loop_in[k].valid <= 1'b1;
    loop_in[k].strength_upd <= upd;
    @(posedge pclk);
    loop_in[k].valid <= 1'b0;
    loop_in[k].strength_upd <= 1'b0;
  endtask : load

  task automatic strobe(int wait_cycles);
    @(posedge pclk);
    frame_strobe <= 1'b1;
    @(posedge pclk);
    frame_strobe <= 1'b0;
    repeat (wait_cycles) @(posedge pclk);
  endtask : strobe

  task automatic wchk(int p, int n, word_kind_t k, int l, logic [15:0] d);
    chk(sink.got[p].size() > n && sink.got[p][n] === {1'b1, k, 3'(l), d},
        "port word");
  endtask : wchk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OFF_ROUTING, 32'h0);
    chk(q === 32'h0000_0000, "routing reset");
    apb(1'b0, OFF_CLK_STREAM, 32'h0);
    chk(q === 32'h0000_0000 && port_clk_oe === 1'b0, "clock reset");
    chk(stream_group === 18'h2C680, "default grouping");
  endtask : t_reset

  task automatic t_samples();
    for (int k = 0; k < 3; k++)
    begin
      load(k, 16'(16'h1111 * (k + 1)), 16'(~(16'h1111 * (k + 1))),
           16'h0000, 1'b0);
      apb(1'b0, 8'(OFF_SAMPLE0_I + 8 * k), 32'h0);
      chk(q[15:0] === 16'(16'h1111 * (k + 1)), "inphase");
      apb(1'b0, 8'(OFF_SAMPLE0_Q + 8 * k), 32'h0);
      chk(q[15:0] === 16'(~(16'h1111 * (k + 1))), "quad");
    end
  endtask : t_samples

  task automatic t_regs();
    apb(1'b1, OFF_ROUTING, 32'hFFFF_FFFF);
    apb(1'b0, OFF_ROUTING, 32'h0);
    chk(q === 32'hFFFF_FFFF, "routing readback");
    apb(1'b1, OFF_CLK_STREAM, 32'hFFFF_FC7F);
    apb(1'b0, OFF_CLK_STREAM, 32'h0);
    chk(q === 32'h0000_007F, "clock field width");
    apb(1'b1, OFF_SAMPLE0_I, 32'h0000_ABCD);
    chk(err === 1'b0, "sample write error");
    apb(1'b0, OFF_SAMPLE0_I, 32'h0);
    chk(q[15:0] === 16'h1111, "sample read only");
    apb(1'b0, 8'h20, 32'h0);
    chk(err === 1'b1, "unmapped read");
  endtask : t_regs

  task automatic t_grouping();
    for (int s = 0; s < 16; s++)
    begin
      apb(1'b1, OFF_CLK_STREAM, 32'(s));
      repeat (2) @(posedge pclk);
      chk(stream_group === grp_tab[s], "stream map");
    end
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, OFF_CLK_STREAM, 32'((c << 4) | 15));
      repeat (2) @(posedge pclk);
      chk(complex_pairs === (c[2] ? 3'h0 : 3'((1 << c[1:0]) - 1)) &&
          biphase_pairs === (c[2] ? 3'((1 << c[1:0]) - 1) : 3'h0),
          "pairing");
    end
  endtask : t_grouping

  task automatic t_div();
    int   rises;
    logic prev;
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, OFF_CLK_STREAM, 32'((d << 8) | 32'h80));
      repeat (4) @(posedge pclk);
      rises = 0;
      prev = port_clk_out;
      repeat (64)
      begin
        @(posedge pclk);
        rises += int'(port_clk_out & ~prev);
        prev = port_clk_out;
      end
      chk(port_clk_oe === 1'b1, "master drive");
      chk((rises - (d > 0 ? 64 >> d : 0)) inside {-1, 0, 1}, "divide");
    end
  endtask : t_div

  task automatic t_master();
    apb(1'b1, OFF_CLK_STREAM, 32'h0000_0080);
    apb(1'b1, OFF_ROUTING, 32'h0000_0081);
    load(0, 16'h1234, 16'hFEDC, 16'h0ABC, 1'b1);
    sink.flush();
    strobe(14);
    strobe(14);
    for (int f = 0; f < 2; f++)
    begin
      wchk(0, 3 * f, WORD_I, 0, 16'h1234);
      wchk(0, 3 * f + 1, WORD_Q, 0, 16'hFEDC);
      wchk(0, 3 * f + 2, WORD_GAIN, 0, 16'h0ABC);
    end
    chk(sink.got[0].size() == 6 && sink.got[1].size() == 0 &&
        sink.got[2].size() == 0, "master counts");
  endtask : t_master

  task automatic t_slave();
    apb(1'b1, OFF_CLK_STREAM, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk(port_clk_oe === 1'b0, "slave pin released");
    apb(1'b1, OFF_ROUTING, 32'h0000_4600);
    load(1, 16'h8101, 16'h7F02, 16'h0000, 1'b0);
    load(2, 16'h3303, 16'hC404, 16'h0777, 1'b1);
    sink.flush();
    clk_run <= 1'b1;
    strobe(80);
    strobe(80);
    clk_run <= 1'b0;
    wchk(1, 0, WORD_IQ8, 1, 16'h817F);
    wchk(1, 1, WORD_IQ8, 2, 16'h33C4);
    wchk(1, 2, WORD_GAIN, 2, 16'h0777);
    wchk(1, 3, WORD_IQ8, 1, 16'h817F);
    wchk(1, 4, WORD_IQ8, 2, 16'h33C4);
    chk(sink.got[1].size() == 5 && sink.got[0].size() == 0,
        "slave counts");
  endtask : t_slave

  task automatic wrap_up();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, frame_strobe, clk_run} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    loop_in = '0;
    grp_tab = '{18'h2C680, 18'h2C600, 18'h2C000, 18'h28000, 18'h00000,
                18'h1B600, 18'h24480, 18'h2C480, 18'h2B600, 18'h24000,
                18'h2C688, 18'h2C688, 18'h2C688, 18'h2C688, 18'h2C688,
                18'h2C688};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_samples();
    t_regs();
    t_grouping();
    t_div();
    t_master();
    t_slave();
    wrap_up();
  end
endmodule : tb_top
